// [rtl/dbc_pkg.sv]
package dbc_pkg;

   // ------------
   // Register indices, byte address is four times
   // ------------
   localparam logic [7:0] ADAPT_IDX     = 8'h01;  // Adaptive coefficient control
   localparam logic [7:0] AUTOMUTE_IDX  = 8'h40;  // DC auto-mute control
   localparam logic [7:0] BEEP_LV_IDX   = 8'h47;  // Left beep volume and enable
   localparam logic [7:0] BEEP_RV_IDX   = 8'h48;  // Right and master volume
   localparam logic [7:0] LEN_A_IDX     = 8'h49;  // Length, high byte
   localparam logic [7:0] LEN_B_IDX     = 8'h4a;  // Length, middle byte
   localparam logic [7:0] LEN_C_IDX     = 8'h4b;  // Length, low byte
   localparam logic [7:0] SIN_A_IDX     = 8'h4c;  // Sine coefficient, high byte
   localparam logic [7:0] SIN_B_IDX     = 8'h4d;  // Sine coefficient, low byte
   localparam logic [7:0] COS_A_IDX     = 8'h4e;  // Cosine coefficient, high byte
   localparam logic [7:0] COS_B_IDX     = 8'h4f;  // Cosine coefficient, low byte
   localparam logic [7:0] RUN_IDX       = 8'h50;  // DAC run control and status
   localparam logic [7:0] CADDR_IDX     = 8'h51;  // Coefficient address pointer
   localparam logic [7:0] CDATA_IDX     = 8'h52;  // Coefficient data window

   // ------------
   // Field positions
   // ------------
   localparam int BEEP_EN_BIT   = 7;  // Beep enable in left volume register
   localparam int ADAPT_EN_BIT  = 2;  // Adaptive mode enable
   localparam int BUF_FLAG_BIT  = 1;  // Buffer in use flag
   localparam int SWAP_BIT      = 0;  // Swap request
   localparam int CSEL_BIT      = 7;  // Buffer select in coefficient address

   // ------------
   // Reset values and sizes
   // ------------
   localparam logic [5:0]  VOL_RESET     = 6'h00;      // 0 dB attenuation
   localparam logic [2:0]  AMUTE_RESET   = 3'h0;       // Auto-mute off
   localparam logic [23:0] LEN_RESET     = 24'h0000ff; // Default burst length
   localparam logic [15:0] SIN_RESET     = 16'h0b50;   // Default sine coefficient
   localparam logic [15:0] COS_RESET     = 16'h7f40;   // Default cosine coefficient
   localparam int          NCOEF         = 70;         // Coefficients per buffer
   localparam logic [9:0]  AMUTE_UNIT    = 10'h200;    // Samples per duration step

   // Beep parameters captured at burst start
   typedef struct packed {
      logic [15:0] sin_c;
      logic [15:0] cos_c;
      logic [5:0]  vol_l;
      logic [5:0]  vol_r;
      logic [1:0]  vol_m;
   } dbc_beep_t;

   // Beep sequencer states
   typedef enum logic [1:0] {
      BP_IDLE = 2'b00,
      BP_PLAY = 2'b01
   } dbc_bstate_t;

endpackage : dbc_pkg

// [rtl/dbc_top.sv]
// Behaviour
// [RQ1] 16-bit sine, cosine set frequency
// [RQ2] Tones up to half rate
// [RQ3] 24-bit length in samples
// [RQ4] Full 24-bit count
// [RQ5] 6-bit volume, 1 dB steps
// [RQ6] Volumes in bits 5-0
// [RQ7] Master volume in bits 7-6
// [RQ8] Volumes reset to 0 dB
// [RQ9] Enable one starts burst
// [RQ10] Enable self-clears at end
// [RQ11] Parameters frozen during burst
// [RQ12] Enable zero stops early
// [RQ13] Mute after DC run
// [RQ14] Auto-mute disabled after reset
// [RQ15] Coefficients locked while running
// [RQ16] Adaptive bit double-buffers
// [RQ17] Swap at next sample
// [RQ18] Swap clears, flag toggles
// [RQ19] Flag shows buffer in use
// [RQ20] Running: write idle buffer
// [RQ21] Stopped: write addressed buffer
// [RQ22] Two buffers of seventy
// [RQ23] Load on start, idle tone zero
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module dbc_top
   import dbc_pkg::*;
(
   input  wire logic        ref_clk,       // 50 MHz clock
   input  wire logic        resetn,        // Asynchronous reset, active low
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // DAC datapath
   input  wire logic        sample_tick,   // One pulse per playback sample
   input  wire logic [15:0] dac_in_l,      // Left input sample
   input  wire logic [15:0] dac_in_r,      // Right input sample
   output logic [15:0]      tone_l,        // Left beep sample
   output logic [15:0]      tone_r,        // Right beep sample
   output logic             tone_active,   // Burst in progress
   output logic             mute_out,      // DC auto-mute active
   input  wire logic [6:0]  coef_rd_idx,   // Engine coefficient index
   output logic [23:0]      coef_rd_data   // Engine coefficient value
);

   // ------------
   // Register state
   // ------------
   logic [5:0]  vol_l_r;          // Left volume
   logic [5:0]  vol_r_r;          // Right volume
   logic [1:0]  vol_m_r;          // Master volume
   logic [23:0] len_r;            // Burst length
   logic [15:0] sin_r;            // Sine coefficient
   logic [15:0] cos_r;            // Cosine coefficient
   logic [2:0]  amute_r;          // Auto-mute duration select
   logic        adapt_r;          // Adaptive mode
   logic        swap_r;           // Pending swap
   logic        buf_r;            // Buffer in use
   logic        run_r;            // DAC running
   logic [7:0]  caddr_r;          // Coefficient pointer
   logic        beep_en_r;        // Beep enable
   dbc_beep_t   bp_r;             // Captured beep parameters
   dbc_bstate_t bst_r;            // Beep state
   logic [23:0] bcnt_r;           // Burst down counter
   logic signed [17:0] osc_a_r;   // Oscillator state n
   logic signed [17:0] osc_b_r;   // Oscillator state n-1
   logic [12:0] dc_cnt_r;         // DC run counter
   logic [15:0] prev_l_r;         // Previous left input
   logic [15:0] prev_r_r;         // Previous right input
   logic [23:0] buf_a [NCOEF];    // Coefficient buffer A
   logic [23:0] buf_b [NCOEF];    // Coefficient buffer B

   // AHB data phase capture
   logic        dp_wr_r;
   logic        dp_rd_r;
   logic [7:0]  dp_idx_r;

   // ------------
   // Helper functions
   // ------------
   // Attenuate a sample by a dB count, 6 dB per shift, 1 dB by table
   function automatic logic signed [17:0] atten(input logic signed [17:0] s,
                                                input logic [6:0] db);
      logic signed [25:0] p;
      logic [7:0]         f;
      p = '0;
      f = '0;
      unique case (7'(db % 7'd6))
         7'd0:    f = 8'hff;
         7'd1:    f = 8'he3;
         7'd2:    f = 8'hcb;
         7'd3:    f = 8'hb5;
         7'd4:    f = 8'ha1;
         default: f = 8'h8f;
      endcase
      p = (26'(s) * $signed({1'b0, f})) >>> 8;
      atten = 18'(p >>> (db / 7'd6));
   endfunction : atten

   // Coefficient index inside range
   function automatic logic idx_ok(input logic [6:0] i);
      idx_ok = (i < 7'(NCOEF));
   endfunction : idx_ok

   // ------------
   // Bus decode
   // ------------
   wire       a_phase  = hsel & htrans[1] & hready;
   wire [7:0] a_idx    = haddr[9:2];
   wire       wr_any   = dp_wr_r;
   wire [7:0] wd       = hwdata[7:0];
   wire       wr_lv    = wr_any & (dp_idx_r == BEEP_LV_IDX);
   wire       burst_on = (bst_r == BP_PLAY);
   wire       smp      = sample_tick;
   wire       coef_sel = caddr_r[CSEL_BIT];
   wire [6:0] cidx     = caddr_r[6:0];
   // [RQ15] Coefficient lock check
   wire       coef_lock = run_r & ~adapt_r;
   // [RQ20] Running writes to idle buffer
   // [RQ21] Stopped writes to addressed buffer
   wire       wr_tgt_b  = run_r ? ~buf_r : coef_sel;
   wire       wr_coef   = wr_any & (dp_idx_r == CDATA_IDX) & ~coef_lock & idx_ok(cidx);
   wire       swap_now  = swap_r & smp & run_r & adapt_r;
   wire       swap_set  = wr_any & (dp_idx_r == ADAPT_IDX) & wd[SWAP_BIT];
   wire       burst_end = burst_on & smp & (bcnt_r == 24'h000001);

   // Constant bus answer
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ------------
   // Data phase tracking
   // ------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dp_wr_r  <= 1'b0;
         dp_rd_r  <= 1'b0;
         dp_idx_r <= 8'h00;
      end else begin
         dp_wr_r  <= a_phase & hwrite;
         dp_rd_r  <= a_phase & ~hwrite;
         dp_idx_r <= a_idx;
      end
   end

   // ------------
   // Parameter registers
   // ------------
   // [RQ8] Volumes reset to 0 dB
   // [RQ14] Auto-mute off at reset
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         vol_l_r <= VOL_RESET;
         vol_r_r <= VOL_RESET;
         vol_m_r <= 2'h0;
         len_r   <= LEN_RESET;
         sin_r   <= SIN_RESET;
         cos_r   <= COS_RESET;
         amute_r <= AMUTE_RESET;
         adapt_r <= 1'b0;
         run_r   <= 1'b0;
         caddr_r <= 8'h00;
      end else if (wr_any) begin
         // [RQ6] Volume fields bits 5-0
         if (dp_idx_r == BEEP_LV_IDX)  vol_l_r <= wd[5:0];
         // [RQ7] Master volume bits 7-6
         if (dp_idx_r == BEEP_RV_IDX)  {vol_m_r, vol_r_r} <= wd;
         // [RQ3] Length over three bytes
         if (dp_idx_r == LEN_A_IDX)    len_r[23:16] <= wd;
         if (dp_idx_r == LEN_B_IDX)    len_r[15:8]  <= wd;
         if (dp_idx_r == LEN_C_IDX)    len_r[7:0]   <= wd;
         // [RQ1] Coefficients over two bytes
         if (dp_idx_r == SIN_A_IDX)    sin_r[15:8]  <= wd;
         if (dp_idx_r == SIN_B_IDX)    sin_r[7:0]   <= wd;
         if (dp_idx_r == COS_A_IDX)    cos_r[15:8]  <= wd;
         if (dp_idx_r == COS_B_IDX)    cos_r[7:0]   <= wd;
         // [RQ13] Duration field bits 6-4
         if (dp_idx_r == AUTOMUTE_IDX) amute_r <= wd[6:4];
         // [RQ16] Adaptive mode bit
         if (dp_idx_r == ADAPT_IDX)    adapt_r <= wd[ADAPT_EN_BIT];
         if (dp_idx_r == RUN_IDX)      run_r   <= wd[0];
         if (dp_idx_r == CADDR_IDX)    caddr_r <= wd;
      end
   end

   // ------------
   // Swap request and buffer flag
   // ------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         swap_r <= 1'b0;
         buf_r  <= 1'b0;
      end else begin
         // [RQ17] Switch at sample start
         // [RQ18] Clear request, toggle flag
         // New request in the switch cycle wins over the clear
         if (swap_set) begin
            swap_r <= 1'b1;
         end else if (swap_now) begin
            swap_r <= 1'b0;
         end
         if (swap_now) buf_r <= ~buf_r;
      end
   end

   // ------------
   // Coefficient buffers
   // ------------
   // [RQ22] Two seventy-entry buffers
   always_ff @(posedge ref_clk) begin
      if (wr_coef & ~wr_tgt_b) buf_a[cidx] <= {16'h0000, wd};
      if (wr_coef & wr_tgt_b)  buf_b[cidx] <= {16'h0000, wd};
   end

   // Engine reads the buffer in use
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         coef_rd_data <= 24'h000000;
      end else if (idx_ok(coef_rd_idx)) begin
         coef_rd_data <= buf_r ? buf_b[coef_rd_idx] : buf_a[coef_rd_idx];
      end
   end

   // ------------
   // Beep sequencer
   // ------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         beep_en_r <= 1'b0;
         bst_r     <= BP_IDLE;
         bcnt_r    <= 24'h000000;
         bp_r      <= '0;
      end else begin
         unique case (bst_r)
            BP_IDLE: begin
               // [RQ9] Start on enable write
               if (wr_lv & wd[BEEP_EN_BIT] & (len_r != 24'h000000)) begin
                  beep_en_r <= 1'b1;
                  bst_r     <= BP_PLAY;
                  // [RQ23] Load counter on start
                  // [RQ4] Full 24-bit length
                  bcnt_r    <= len_r;
                  // [RQ11] Capture frozen parameters
                  bp_r      <= '{sin_c: sin_r, cos_c: cos_r, vol_l: vol_l_r,
                                 vol_r: vol_r_r, vol_m: vol_m_r};
               end
            end
            BP_PLAY: begin
               // [RQ12] Early stop by host
               if (wr_lv & ~wd[BEEP_EN_BIT]) begin
                  beep_en_r <= 1'b0;
                  bst_r     <= BP_IDLE;
               // [RQ10] Self-clear at end
               end else if (burst_end) begin
                  beep_en_r <= 1'b0;
                  bst_r     <= BP_IDLE;
               end else if (smp) begin
                  // [RQ23] Decrement per sample
                  bcnt_r <= bcnt_r - 24'h000001;
               end
            end
         endcase
      end
   end

   // ------------
   // Recursive sine oscillator
   // ------------
   // y[n+1] = 2*cos*y[n] - y[n-1], seeded with the sine coefficient;
   // [RQ2] Cosine in Q15 reaches any tone up to half rate
   wire signed [33:0] osc_prod = $signed(bp_r.cos_c) * osc_a_r;
   wire signed [17:0] osc_next = 18'(osc_prod >>> 14) - osc_b_r;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         osc_a_r <= 18'sh00000;
         osc_b_r <= 18'sh00000;
      end else if (bst_r == BP_IDLE) begin
         osc_a_r <= $signed({{2{sin_r[15]}}, sin_r});
         osc_b_r <= 18'sh00000;
      end else if (smp) begin
         osc_a_r <= osc_next;
         osc_b_r <= osc_a_r;
      end
   end

   // ------------
   // Tone output with volume
   // ------------
   // [RQ5] 6-bit channel attenuation plus master
   wire [6:0] db_l = 7'(bp_r.vol_l) + 7'({bp_r.vol_m, 2'b00});
   wire [6:0] db_r = 7'(bp_r.vol_r) + 7'({bp_r.vol_m, 2'b00});
   wire signed [17:0] att_l = atten(osc_a_r, db_l);
   wire signed [17:0] att_r = atten(osc_a_r, db_r);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tone_l      <= 16'h0000;
         tone_r      <= 16'h0000;
         tone_active <= 1'b0;
      end else begin
         tone_active <= burst_on;
         // [RQ23] Zero tone when disabled
         tone_l <= burst_on ? att_l[15:0] : 16'h0000;
         tone_r <= burst_on ? att_r[15:0] : 16'h0000;
      end
   end

   // ------------
   // DC auto-mute detector
   // ------------
   wire        in_dc   = (dac_in_l == prev_l_r) & (dac_in_r == prev_r_r);
   wire [12:0] dc_lim  = 13'(amute_r) * 13'(AMUTE_UNIT);

   // [RQ13] Mute after DC run
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prev_l_r <= 16'h0000;
         prev_r_r <= 16'h0000;
         dc_cnt_r <= 13'h0000;
         mute_out <= 1'b0;
      end else if (amute_r == 3'h0) begin
         dc_cnt_r <= 13'h0000;
         mute_out <= 1'b0;
      end else if (smp) begin
         prev_l_r <= dac_in_l;
         prev_r_r <= dac_in_r;
         if (!in_dc) begin
            dc_cnt_r <= 13'h0000;
            mute_out <= 1'b0;
         end else if (dc_cnt_r >= dc_lim) begin
            mute_out <= 1'b1;
         end else begin
            dc_cnt_r <= dc_cnt_r + 13'h0001;
         end
      end
   end

   // ------------
   // Read mux
   // ------------
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      unique case (dp_idx_r)
         // [RQ19] Buffer flag readable
         ADAPT_IDX:    rd_byte = {5'h00, adapt_r, buf_r, swap_r};
         AUTOMUTE_IDX: rd_byte = {1'b0, amute_r, 4'h0};
         BEEP_LV_IDX:  rd_byte = {beep_en_r, 1'b0, vol_l_r};
         BEEP_RV_IDX:  rd_byte = {vol_m_r, vol_r_r};
         LEN_A_IDX:    rd_byte = len_r[23:16];
         LEN_B_IDX:    rd_byte = len_r[15:8];
         LEN_C_IDX:    rd_byte = len_r[7:0];
         SIN_A_IDX:    rd_byte = sin_r[15:8];
         SIN_B_IDX:    rd_byte = sin_r[7:0];
         COS_A_IDX:    rd_byte = cos_r[15:8];
         COS_B_IDX:    rd_byte = cos_r[7:0];
         RUN_IDX:      rd_byte = {6'h00, mute_out, run_r};
         CADDR_IDX:    rd_byte = caddr_r;
         // [RQ15] Locked reads return zero
         CDATA_IDX:    rd_byte = (coef_lock | ~idx_ok(cidx)) ? 8'h00 :
                                 (coef_sel ? buf_b[cidx][7:0] : buf_a[cidx][7:0]);
         default:      rd_byte = 8'h00;
      endcase
   end

   assign hrdata = dp_rd_r ? {24'h000000, rd_byte} : 32'h00000000;

endmodule : dbc_top

// [bench/dbc_assertions.sv]
`timescale 1ns/1ps
module dbc_assertions
   import dbc_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        sample_tick,
   input wire logic [15:0] dac_in_l,
   input wire logic [15:0] dac_in_r,
   input wire logic [15:0] tone_l,
   input wire logic [15:0] tone_r,
   input wire logic        tone_active,
   input wire logic        mute_out,
   input wire logic [6:0]  coef_rd_idx,
   input wire logic [23:0] coef_rd_data
);
   // ------------------------------------------------------------
   // Data phase tracking
   // ------------------------------------------------------------
   logic        ph_rd_r;    // Read in data phase
   logic        ph_wr_r;    // Write in data phase
   logic [31:0] ph_addr_r;  // Address of data phase
   wire logic   addr_ph  = hsel & htrans[1] & hready;
   wire logic   lv_hit   = ph_wr_r && (ph_addr_r == {22'h0, BEEP_LV_IDX, 2'b00});
   wire logic   unmapped = ph_rd_r && (ph_addr_r[31:10] != 22'h0 || ph_addr_r[9:2] > CDATA_IDX);

   // Capture each accepted address phase
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ph_rd_r   <= 1'b0;
         ph_wr_r   <= 1'b0;
         ph_addr_r <= 32'h0;
      end else begin
         ph_rd_r   <= addr_ph & ~hwrite;
         ph_wr_r   <= addr_ph & hwrite;
         ph_addr_r <= haddr;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   AST_READY: assert property (hreadyout == 1'b1)
      else $error("hreadyout low");
   AST_RESP: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   AST_HI_ZERO: assert property (hrdata[31:8] == 24'h0)
      else $error("hrdata upper bits set");
   AST_UNMAPPED: assert property (unmapped |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   AST_START: assert property (lv_hit && hwdata[BEEP_EN_BIT] |-> ##[1:3] tone_active)
      else $error("burst did not start");
   AST_STOP: assert property (lv_hit && !hwdata[BEEP_EN_BIT] |-> ##[1:3] !tone_active)
      else $error("burst did not stop");
   AST_TONE_IDLE: assert property (!tone_active [*3] |-> $past(tone_l) == 16'h0 && $past(tone_r) == 16'h0)
      else $error("tone while idle");
   AST_STOP_ZERO: assert property ($fell(tone_active) |-> ##1 (tone_l == 16'h0 && tone_r == 16'h0))
      else $error("tone after burst end");
   AST_MUTE_TICK: assert property ($rose(mute_out) |-> $past(sample_tick) || $past(sample_tick, 2))
      else $error("mute off sample boundary");
   AST_MUTE_DC: assert property ($rose(mute_out) |-> $past(dac_in_l, 2) == $past(dac_in_l, 3))
      else $error("mute without dc input");
endmodule : dbc_assertions

bind dbc_top dbc_assertions i_chk (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .sample_tick(sample_tick), .dac_in_l(dac_in_l), .dac_in_r(dac_in_r), .tone_l(tone_l),
   .tone_r(tone_r), .tone_active(tone_active), .mute_out(mute_out),
   .coef_rd_idx(coef_rd_idx), .coef_rd_data(coef_rd_data));

// [bench/dbc_dac_model.sv]
`timescale 1ns/1ps
module dbc_dac_model #(
   parameter int TICK_DIV = 4  // Clocks per playback sample
) (
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        dc_mode,     // Hold input constant
   output logic             sample_tick,
   output logic [15:0]      dac_in_l,
   output logic [15:0]      dac_in_r
);
   logic [7:0] div_r;  // Sample period divider

   // ------------------------------------------------------------
   // Sample clock and input stream
   // ------------------------------------------------------------
   // one tick per sample period
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         div_r       <= 8'h00;
         sample_tick <= 1'b0;
         dac_in_l    <= 16'h1234;
         dac_in_r    <= 16'h4321;
      end else begin
         div_r       <= (div_r == 8'(TICK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
         sample_tick <= (div_r == 8'(TICK_DIV - 1));
         // Changing stream breaks any DC run
         if (sample_tick && !dc_mode) begin
            dac_in_l <= dac_in_l + 16'h0101;
            dac_in_r <= ~dac_in_l;
         end
      end
   end
endmodule : dbc_dac_model

// [bench/dbc_top_tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module dbc_top_tb_top;
   import dbc_pkg::*;
   typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} dbc_row_t;
   logic        ref_clk, resetn, hsel, hwrite, dc_mode, hreadyout, hresp;
   logic        sample_tick, tone_active, mute_out, nz_seen;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] dac_in_l, dac_in_r, tone_l, tone_r;
   logic [6:0]  coef_rd_idx;
   logic [23:0] coef_rd_data;
   logic [7:0]  rd;
   int          err_total, comparisons, ticks, t0, i;
   wire logic   hready = hreadyout;  // Single slave drives hready
   dbc_row_t    rows [0:19] = '{'{BEEP_LV_IDX, 8'h3f, 8'h3f}, '{BEEP_RV_IDX, 8'hff, 8'hff},
      '{LEN_A_IDX, 8'h00, 8'h00}, '{LEN_B_IDX, 8'h00, 8'h00}, '{LEN_C_IDX, 8'h04, 8'h04},
      '{SIN_A_IDX, 8'h0c, 8'h0c}, '{SIN_B_IDX, 8'h00, 8'h00}, '{COS_A_IDX, 8'h7f, 8'h7f},
      '{COS_B_IDX, 8'h00, 8'h00}, '{AUTOMUTE_IDX, 8'h70, 8'h70}, '{AUTOMUTE_IDX, 8'h00, 8'h00},
      '{8'h60, 8'haa, 8'h00}, '{CADDR_IDX, 8'h05, 8'h05}, '{CDATA_IDX, 8'h5a, 8'h5a},
      '{CADDR_IDX, 8'h85, 8'h85}, '{CDATA_IDX, 8'ha5, 8'ha5}, '{CADDR_IDX, 8'h45, 8'h45},
      '{CDATA_IDX, 8'h3c, 8'h3c}, '{CADDR_IDX, 8'h46, 8'h46}, '{CDATA_IDX, 8'h77, 8'h00}};

   // ------------------------------------------------------------
   // Design, far side and clock
   // ------------------------------------------------------------
   dbc_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_tick(sample_tick),
      .dac_in_l(dac_in_l), .dac_in_r(dac_in_r), .tone_l(tone_l), .tone_r(tone_r),
      .tone_active(tone_active), .mute_out(mute_out), .coef_rd_idx(coef_rd_idx),
      .coef_rd_data(coef_rd_data));
   dbc_dac_model i_dac (.ref_clk(ref_clk), .resetn(resetn), .dc_mode(dc_mode),
      .sample_tick(sample_tick), .dac_in_l(dac_in_l), .dac_in_r(dac_in_r));
   always #10 ref_clk = ~ref_clk;
   // Sample counter and tone activity monitor
   always @(posedge ref_clk) begin
      if (sample_tick === 1'b1) ticks++;
      if (tone_l !== 16'h0 || tone_r !== 16'h0) nz_seen = 1'b1;
   end

   // ------------------------------------------------------------
   // Bus and wait tasks
   // ------------------------------------------------------------
   task automatic rdy_wait;
      int k;
      k = 0;
      while (hready !== 1'b1) begin
         @(posedge ref_clk);
         k++;
         if (k > 50) begin err_total++; $display("CHECK FAILED hready exp 1 got 0"); finish_test(); end
      end
   endtask : rdy_wait
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge ref_clk);
      rdy_wait();
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      @(posedge ref_clk);
      rdy_wait();
      rd = hrdata[7:0];
   endtask : bus
   task automatic wait_for(input int sel, input logic lvl, input int bound);
      int k;
      k = 0;
      while (((sel == 0) ? tone_active : mute_out) !== lvl) begin
         @(posedge ref_clk);
         k++;
         if (k > bound) begin err_total++; $display("CHECK FAILED wait %0d exp %h got none", sel, lvl); finish_test(); end
      end
   endtask : wait_for
   task automatic wait_ticks(input int n);
      t0 = ticks;
      for (int k = 0; k < 40 * n && ticks < t0 + n; k++) @(posedge ref_clk);
   endtask : wait_ticks
   task finish_test;
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      ref_clk = 0; resetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
      hwdata = 0; dc_mode = 1; coef_rd_idx = 7'h05; err_total = 0; comparisons = 0; ticks = 0;
      nz_seen = 0;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      for (i = 0; i < 20; i++) begin
         bus(rows[i].idx, 1'b1, rows[i].wd);
         bus(rows[i].idx, 1'b0, 8'h00);
         `CHK("row", rows[i].ex, rd);
      end
      bus(CADDR_IDX, 1'b1, 8'h05);
      bus(CDATA_IDX, 1'b0, 8'h00);
      `CHK("buf a", 8'h5a, rd);
      `CHK("engine a", 8'h5a, coef_rd_data[7:0]);
      $display("TEST table done");
      // Running: blocked, then adaptive swaps
      bus(RUN_IDX, 1'b1, 8'h01);
      bus(CDATA_IDX, 1'b1, 8'h11);
      bus(CDATA_IDX, 1'b0, 8'h00);
      `CHK("locked", 8'h00, rd);
      bus(ADAPT_IDX, 1'b1, 8'h04);
      bus(CDATA_IDX, 1'b1, 8'h33);
      bus(ADAPT_IDX, 1'b0, 8'h00);
      `CHK("adapt", 8'h04, rd);
      bus(ADAPT_IDX, 1'b1, 8'h05);
      wait_ticks(2);
      bus(ADAPT_IDX, 1'b0, 8'h00);
      `CHK("swap b", 8'h06, rd);
      `CHK("engine b", 8'h33, coef_rd_data[7:0]);
      bus(CADDR_IDX, 1'b1, 8'h85);
      bus(CDATA_IDX, 1'b1, 8'h44);
      bus(ADAPT_IDX, 1'b1, 8'h05);
      wait_ticks(2);
      bus(ADAPT_IDX, 1'b0, 8'h00);
      `CHK("swap a", 8'h04, rd);
      `CHK("engine a2", 8'h44, coef_rd_data[7:0]);
      bus(RUN_IDX, 1'b1, 8'h00);
      bus(ADAPT_IDX, 1'b1, 8'h00);
      $display("TEST coefficient done");
      // Burst runs its length, then self-clears
      bus(BEEP_RV_IDX, 1'b1, 8'h00);
      bus(BEEP_LV_IDX, 1'b1, 8'h80);
      wait_for(0, 1'b1, 20);
      t0 = ticks;
      nz_seen = 0;
      wait_for(0, 1'b0, 200);
      `CHK("length", 1'b1, (ticks - t0 >= 3 && ticks - t0 <= 5));
      `CHK("tone", 1'b1, nz_seen);
      bus(BEEP_LV_IDX, 1'b0, 8'h00);
      `CHK("self clear", 8'h00, rd);
      // Long burst: frozen length, early stop
      bus(LEN_C_IDX, 1'b1, 8'hff);
      bus(BEEP_LV_IDX, 1'b1, 8'h80);
      wait_for(0, 1'b1, 20);
      bus(LEN_C_IDX, 1'b1, 8'h01);
      wait_ticks(10);
      `CHK("frozen", 1'b1, tone_active);
      bus(BEEP_LV_IDX, 1'b1, 8'h00);
      wait_for(0, 1'b0, 20);
      wait_ticks(1);
      `CHK("stopped", 16'h0, tone_l);
      $display("TEST beep done");
      // DC run mutes after field times unit samples
      `CHK("no mute", 1'b0, mute_out);
      bus(AUTOMUTE_IDX, 1'b1, 8'h10);
      i = ticks;
      wait_for(1, 1'b1, 4000);
      `CHK("mute time", 1'b1, (ticks - i >= 511 && ticks - i <= 514));
      bus(RUN_IDX, 1'b0, 8'h00);
      `CHK("mute flag", 8'h02, rd);
      dc_mode <= 1'b0;
      wait_for(1, 1'b0, 100);
      $display("TEST mute done");
      // Second reset restores defaults
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      bus(BEEP_LV_IDX, 1'b0, 8'h00);
      `CHK("rst lv", 8'h00, rd);
      bus(BEEP_RV_IDX, 1'b0, 8'h00);
      `CHK("rst rv", 8'h00, rd);
      bus(AUTOMUTE_IDX, 1'b0, 8'h00);
      `CHK("rst mute", 8'h00, rd);
      bus(LEN_C_IDX, 1'b0, 8'h00);
      `CHK("rst len", LEN_RESET[7:0], rd);
      bus(SIN_A_IDX, 1'b0, 8'h00);
      `CHK("rst sin", SIN_RESET[15:8], rd);
      bus(ADAPT_IDX, 1'b0, 8'h00);
      `CHK("rst adapt", 8'h00, rd);
      $display("TEST reset done");
      finish_test();
   end
endmodule : dbc_top_tb_top
